/* logic/battery_switchover_monitor.sv */
// battery switchover monitor: selects rail source, latches supply events, shared interrupt
// assumes: comparator and pin inputs are asynchronous; adc strobes and sfr bus are synchronous to clk_sys_in
`timescale 1ns/1ns
module battery_switchover_monitor #(
  parameter int QUALIFY_CYCLES = supply_monitor_pkg::QUALIFY_CYCLES,
  parameter int DC_TIMEOUT_CYC = supply_monitor_pkg::DC_TIMEOUT_CYC,
  parameter int ADC_PERIOD_CYC = supply_monitor_pkg::ADC_PERIOD_CYC
) (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // sfr bus
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // analog comparators and pins
  input  wire logic       dc_input_low_in,
  input  wire logic       main_supply_low_in,
  input  wire logic       battery_force_pin_in,
  input  wire logic       line_dip_event_in,
  // measurement adcs
  input  wire logic       rail_adc_done_in,
  input  wire logic [7:0] rail_adc_result_in,
  input  wire logic       battery_adc_done_in,
  input  wire logic [7:0] battery_adc_result_in,
  output logic            rail_adc_start_out,
  // outputs
  output logic            rail_on_battery_out,
  output logic            power_irq_out,
  output logic      [2:0] power_ctrl_out
);
  localparam int T_BITS = 32;

  // synchronisers: two stages, only the second stage is read onward
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] async_in;
  assign async_in = {line_dip_event_in, battery_force_pin_in, main_supply_low_in, dc_input_low_in};

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  logic dc_low;
  logic main_low;
  logic pin_s;
  logic dip_s;
  logic pin_prev_q;
  logic dip_prev_q;
  assign dc_low   = sync2_q[0];
  assign main_low = sync2_q[1];
  assign pin_s    = sync2_q[2];
  assign dip_s    = sync2_q[3];
  // edge detectors reset low, the idle level of both pins, so reset gives no false edge

  // registers
  logic [7:0] irq_en_prio2_q;
  logic [7:0] power_irq_en_q;
  logic [7:0] delta_cfg_q;
  logic [7:0] peripheral_config_cfg_q;
  logic [7:0] switch_cfg_q;
  logic [7:0] battery_thresh_q;
  logic [7:0] irq_pin_cfg_q;
  logic [7:0] battery_result_q;
  logic [7:0] rail_last_q;
  logic [2:0] power_ctrl_q;
  logic       key_ok_q;
  logic [supply_monitor_pkg::NUM_EVENTS-1:0] flags_q;

  function automatic logic hit(input logic [7:0] addr);
    hit = sfr_wr_in && (sfr_addr_in == addr);
  endfunction

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_en_prio2_q   <= supply_monitor_pkg::RST_ZERO;
      power_irq_en_q   <= supply_monitor_pkg::RST_ZERO;
      delta_cfg_q      <= supply_monitor_pkg::RST_ZERO;
      peripheral_config_cfg_q     <= supply_monitor_pkg::RST_ZERO;
      switch_cfg_q     <= supply_monitor_pkg::RST_SWITCH_CFG;
      battery_thresh_q <= supply_monitor_pkg::RST_ZERO;
      irq_pin_cfg_q    <= supply_monitor_pkg::RST_ZERO;
    end else begin
      if (hit(supply_monitor_pkg::ADDR_IRQ_EN_PRIO2))   irq_en_prio2_q   <= sfr_wdata_in;
      if (hit(supply_monitor_pkg::ADDR_POWER_IRQ_EN))   power_irq_en_q   <= sfr_wdata_in;
      if (hit(supply_monitor_pkg::ADDR_DELTA_CFG))      delta_cfg_q      <= sfr_wdata_in;
      if (hit(supply_monitor_pkg::ADDR_PERIPHERAL_CONFIG_CFG))     peripheral_config_cfg_q     <= sfr_wdata_in;
      if (hit(supply_monitor_pkg::ADDR_SWITCH_CFG))     switch_cfg_q     <= sfr_wdata_in;
      if (hit(supply_monitor_pkg::ADDR_BATTERY_THRESH)) battery_thresh_q <= sfr_wdata_in;
      if (hit(supply_monitor_pkg::ADDR_IRQ_PIN_CFG))    irq_pin_cfg_q    <= sfr_wdata_in;
    end
  end

  // key unlock: any bus write other than the key itself drops the unlock
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      key_ok_q     <= 1'b0;
      power_ctrl_q <= supply_monitor_pkg::RST_POWER_CTRL;
    end else if (sfr_wr_in) begin
      key_ok_q <= hit(supply_monitor_pkg::ADDR_WRITE_KEY) &&
                  (sfr_wdata_in == supply_monitor_pkg::WRITE_KEY_VALUE);
      if (hit(supply_monitor_pkg::ADDR_POWER_CONTROL) && key_ok_q) begin
        power_ctrl_q <= sfr_wdata_in[2:0];
      end
    end
  end
  assign power_ctrl_out = power_ctrl_q;

  // switchover causes
  logic sw_disabled;
  logic dc_cause_en;
  logic main_cause_en;
  logic pin_cause_en;
  assign sw_disabled   = switch_cfg_q[supply_monitor_pkg::BIT_PROG_HI];
  assign dc_cause_en   = ~switch_cfg_q[supply_monitor_pkg::BIT_PROG_HI] &
                         ~switch_cfg_q[supply_monitor_pkg::BIT_PROG_LO];
  assign main_cause_en = ~switch_cfg_q[supply_monitor_pkg::BIT_PROG_HI];
  assign pin_cause_en  = (irq_pin_cfg_q[supply_monitor_pkg::BIT_EXT1_LO +: 2] ==
                          supply_monitor_pkg::EXT1_FORCE_CODE);

  // dc low delay selected by timeout field: 1x, 2x, 4x, 8x of the base count
  logic [T_BITS-1:0] dc_timer_q;
  logic [T_BITS-1:0] dc_limit;
  logic              dc_trip;
  assign dc_limit = T_BITS'(DC_TIMEOUT_CYC) <<
                    switch_cfg_q[supply_monitor_pkg::BIT_TIMEOUT_LO +: 2];
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !dc_low) begin
      dc_timer_q <= '0;
    end else if (dc_timer_q < dc_limit) begin
      dc_timer_q <= dc_timer_q + T_BITS'(1);
    end
  end
  assign dc_trip = dc_low && (dc_timer_q >= dc_limit);

  // qualification timers for return to main
  logic [T_BITS-1:0] main_good_q;
  logic [T_BITS-1:0] dc_good_q;
  logic              main_qual;
  logic              dc_qual;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || main_low) begin
      main_good_q <= '0;
    end else if (main_good_q < T_BITS'(QUALIFY_CYCLES)) begin
      main_good_q <= main_good_q + T_BITS'(1);
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || dc_low) begin
      dc_good_q <= '0;
    end else if (dc_good_q < T_BITS'(QUALIFY_CYCLES)) begin
      dc_good_q <= dc_good_q + T_BITS'(1);
    end
  end
  assign main_qual = main_good_q >= T_BITS'(QUALIFY_CYCLES);
  assign dc_qual   = dc_good_q >= T_BITS'(QUALIFY_CYCLES);

  // rail source state
  typedef enum logic [1:0] {
    ON_MAIN    = 2'b01,
    ON_BATTERY = 2'b10
  } rail_state_t;
  rail_state_t rail_q;
  logic go_battery;
  logic go_main;
  logic pin_rise;
  assign pin_rise   = pin_s & ~pin_prev_q;
  assign go_battery = (dc_cause_en & dc_trip) |
                      (main_cause_en & main_low) |
                      (pin_cause_en & pin_rise);
  assign go_main = sw_disabled ||
                   ((!dc_cause_en || dc_qual) && main_qual &&
                    (!pin_cause_en || !pin_s));

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rail_q     <= ON_MAIN;
      pin_prev_q <= 1'b0;
      dip_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_s;
      dip_prev_q <= dip_s;
      unique case (rail_q)
        ON_MAIN:    if (go_battery && !sw_disabled) rail_q <= ON_BATTERY;
        ON_BATTERY: if (go_main) rail_q <= ON_MAIN;
        default:    rail_q <= ON_MAIN;
      endcase
    end
  end
  assign rail_on_battery_out = (rail_q == ON_BATTERY);

  logic to_battery;
  logic to_main;
  assign to_battery = (rail_q == ON_MAIN) && go_battery && !sw_disabled;
  assign to_main    = (rail_q == ON_BATTERY) && go_main;

  // rail and battery adc handling
  // a start write landing on the periodic tick still gives a single pulse
  logic [T_BITS-1:0] adc_timer_q;
  logic              adc_start_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      adc_timer_q <= '0;
      adc_start_q <= 1'b0;
    end else begin
      adc_start_q <= hit(supply_monitor_pkg::ADDR_ADC_START) ||
                     (adc_timer_q == T_BITS'(ADC_PERIOD_CYC - 1));
      adc_timer_q <= (adc_timer_q == T_BITS'(ADC_PERIOD_CYC - 1)) ? '0 : adc_timer_q + T_BITS'(1);
    end
  end
  assign rail_adc_start_out = adc_start_q;

  // adc done strobes come from the same clock domain
  logic [7:0] rail_diff;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rail_last_q      <= supply_monitor_pkg::RST_ZERO;
      battery_result_q <= supply_monitor_pkg::RST_ZERO;
    end else begin
      if (rail_adc_done_in) rail_last_q <= rail_adc_result_in;
      if (battery_adc_done_in) battery_result_q <= battery_adc_result_in;
    end
  end
  assign rail_diff = (rail_adc_result_in > rail_last_q) ? rail_adc_result_in - rail_last_q
                                                        : rail_last_q - rail_adc_result_in;

  // event flags
  logic [supply_monitor_pkg::NUM_EVENTS-1:0] set_ev;
  logic [supply_monitor_pkg::NUM_EVENTS-1:0] clr_ev;
  always_comb begin
    set_ev = '0;
    set_ev[supply_monitor_pkg::BIT_SWITCHOVER] = to_battery;
    set_ev[supply_monitor_pkg::BIT_RESTORED]   = to_main;
    set_ev[supply_monitor_pkg::BIT_RAIL_DELTA] = rail_adc_done_in && (rail_diff > delta_cfg_q);
    set_ev[supply_monitor_pkg::BIT_BATTERY]    = battery_adc_done_in;
    set_ev[supply_monitor_pkg::BIT_BATTERY]    = set_ev[supply_monitor_pkg::BIT_BATTERY] ||
                                                 (battery_result_q < battery_thresh_q);
    set_ev[supply_monitor_pkg::BIT_DC_LOW]     = dc_low;
    set_ev[supply_monitor_pkg::BIT_LINE_DIP]   = dip_s & ~dip_prev_q;
    clr_ev = hit(supply_monitor_pkg::ADDR_POWER_FLAGS) ? ~sfr_wdata_in[supply_monitor_pkg::NUM_EVENTS-1:0]
                                                       : '0;
  end

  // set is tested first: an event landing with a software clear must not be lost
  genvar g;
  generate
    for (g = 0; g < supply_monitor_pkg::NUM_EVENTS; g++) begin : g_flag
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          flags_q[g] <= 1'b0;
        end else if (set_ev[g]) begin
          flags_q[g] <= 1'b1;
        end else if (clr_ev[g]) begin
          flags_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  logic irq_pending;
  assign irq_pending   = |(flags_q & power_irq_en_q[supply_monitor_pkg::NUM_EVENTS-1:0]);
  assign power_irq_out = irq_pending & irq_en_prio2_q[supply_monitor_pkg::BIT_MASTER_EN];

  // read mux
  logic [7:0] peripheral_config_view;
  always_comb begin
    peripheral_config_view = peripheral_config_cfg_q;
    peripheral_config_view[supply_monitor_pkg::BIT_RAIL_ON_MAIN] = (rail_q == ON_MAIN);
  end
  always_comb begin
    sfr_rdata_out = 8'h00;
    if (sfr_rd_in) begin
      unique case (sfr_addr_in)
        supply_monitor_pkg::ADDR_IRQ_EN_PRIO2:   sfr_rdata_out = irq_en_prio2_q;
        supply_monitor_pkg::ADDR_ADC_START:      sfr_rdata_out = 8'h00;
        supply_monitor_pkg::ADDR_BATTERY_RESULT: sfr_rdata_out = battery_result_q;
        supply_monitor_pkg::ADDR_POWER_IRQ_EN:   sfr_rdata_out = power_irq_en_q;
        supply_monitor_pkg::ADDR_DELTA_CFG:      sfr_rdata_out = delta_cfg_q;
        supply_monitor_pkg::ADDR_PERIPHERAL_CONFIG_CFG:     sfr_rdata_out = peripheral_config_view;
        supply_monitor_pkg::ADDR_SWITCH_CFG:     sfr_rdata_out = switch_cfg_q;
        supply_monitor_pkg::ADDR_POWER_FLAGS:    sfr_rdata_out = 8'(flags_q);
        supply_monitor_pkg::ADDR_BATTERY_THRESH: sfr_rdata_out = battery_thresh_q;
        supply_monitor_pkg::ADDR_IRQ_PIN_CFG:    sfr_rdata_out = irq_pin_cfg_q;
        supply_monitor_pkg::ADDR_POWER_CONTROL:  sfr_rdata_out = {5'h00, power_ctrl_q};
        default:                                 sfr_rdata_out = 8'h00;
      endcase
    end
  end

  // assertions
  a_irq_master_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !irq_en_prio2_q[supply_monitor_pkg::BIT_MASTER_EN] |-> !power_irq_out)
    else $error("interrupt delivered without master enable");
  a_irq_any_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (irq_pending && irq_en_prio2_q[supply_monitor_pkg::BIT_MASTER_EN]) |-> power_irq_out)
    else $error("enabled flag did not raise interrupt");
  a_switch_flag_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ($rose(rail_q == ON_BATTERY)) |-> flags_q[supply_monitor_pkg::BIT_SWITCHOVER])
    else $error("switchover flag missing");
  a_restore_flag_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ($fell(rail_q == ON_BATTERY)) |-> flags_q[supply_monitor_pkg::BIT_RESTORED])
    else $error("restored flag missing");
  a_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (flags_q[supply_monitor_pkg::BIT_SWITCHOVER] && !hit(supply_monitor_pkg::ADDR_POWER_FLAGS))
      |=> flags_q[supply_monitor_pkg::BIT_SWITCHOVER])
    else $error("flag dropped without clear");
  a_disable_holds: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    sw_disabled |=> (rail_q == ON_MAIN))
    else $error("rail on battery while switchover disabled");
  a_main_low_switch: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (rail_q == ON_MAIN && main_low && main_cause_en) |=> (rail_q == ON_BATTERY))
    else $error("main low did not switch");
  a_return_qualified: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (rail_q == ON_BATTERY && !sw_disabled && !main_qual) |=> (rail_q == ON_BATTERY))
    else $error("returned to main before qualification");
  a_key_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (hit(supply_monitor_pkg::ADDR_POWER_CONTROL) && !key_ok_q) |=> $stable(power_ctrl_q))
    else $error("power control written without key");
  a_pin_force: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (rail_q == ON_MAIN && !sw_disabled && pin_cause_en && pin_rise) |=> (rail_q == ON_BATTERY))
    else $error("force pin did not switch");
  a_pin_holds: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (rail_q == ON_BATTERY && !sw_disabled && pin_cause_en && pin_s) |=> (rail_q == ON_BATTERY))
    else $error("returned to main while force pin high");
  a_dc_timeout: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (rail_q == ON_MAIN && dc_low && dc_timer_q < dc_limit && !main_low && !pin_rise) |=> (rail_q == ON_MAIN))
    else $error("dc low switched before its timeout");
  a_dc_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    dc_low |=> flags_q[supply_monitor_pkg::BIT_DC_LOW])
    else $error("dc low flag missing");
  a_set_wins: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (set_ev[supply_monitor_pkg::BIT_DC_LOW] && clr_ev[supply_monitor_pkg::BIT_DC_LOW])
      |=> flags_q[supply_monitor_pkg::BIT_DC_LOW])
    else $error("clear beat a same cycle set");
  a_dip_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (dip_s && !dip_prev_q) |=> flags_q[supply_monitor_pkg::BIT_LINE_DIP])
    else $error("line dip flag missing");
  a_sync_stages: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(main_low) |-> ($past(main_supply_low_in, 2) && !$past(main_supply_low_in, 3)))
    else $error("main supply low reached logic without two stages");
endmodule

/* logic/supply_monitor_pkg.sv */
// package: register addresses, field positions, reset values and timing for the supply monitor
// assumes: special function register bus of the core, 8-bit data, 8-bit address
package supply_monitor_pkg;
  // register addresses on the special function register bus
  localparam logic [7:0] ADDR_IRQ_EN_PRIO2   = 8'ha9;
  localparam logic [7:0] ADDR_ADC_START      = 8'hd8;
  localparam logic [7:0] ADDR_BATTERY_RESULT = 8'hdf;
  localparam logic [7:0] ADDR_POWER_IRQ_EN   = 8'hec;
  localparam logic [7:0] ADDR_DELTA_CFG      = 8'hf3;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_CFG     = 8'hf4;
  localparam logic [7:0] ADDR_SWITCH_CFG     = 8'hf5;
  localparam logic [7:0] ADDR_POWER_FLAGS    = 8'hf8;
  localparam logic [7:0] ADDR_BATTERY_THRESH = 8'hfa;
  localparam logic [7:0] ADDR_IRQ_PIN_CFG    = 8'hff;
  localparam logic [7:0] ADDR_WRITE_KEY      = 8'ha7;
  localparam logic [7:0] ADDR_POWER_CONTROL  = 8'hc5;
  localparam logic [7:0] WRITE_KEY_VALUE     = 8'ha7;

  // flag and enable bit positions, shared by the flag and enable registers
  localparam int BIT_SWITCHOVER = 0;
  localparam int BIT_RESTORED   = 1;
  localparam int BIT_RAIL_DELTA = 2;
  localparam int BIT_BATTERY    = 3;
  localparam int BIT_DC_LOW     = 4;
  localparam int BIT_LINE_DIP   = 5;
  localparam int NUM_EVENTS     = 6;

  // other field positions
  localparam int BIT_MASTER_EN      = 7;
  localparam int BIT_RAIL_ON_MAIN   = 6;
  localparam int BIT_PROG_LO        = 0;
  localparam int BIT_PROG_HI        = 1;
  localparam int BIT_TIMEOUT_LO     = 2;
  localparam int BIT_EXT1_LO        = 2;
  localparam int BIT_EXT1_HI        = 4;
  localparam logic [1:0] EXT1_FORCE_CODE = 2'h1;

  // reset values
  localparam logic [7:0] RST_SWITCH_CFG = 8'h01;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_CONFIG_CFG = 8'h40;
  localparam logic [2:0] RST_POWER_CTRL = 3'h2;

  // timing
  localparam int CLK_HZ           = 20_000_000;
  localparam int QUALIFY_US       = 1000;
  localparam int QUALIFY_CYCLES   = QUALIFY_US * (CLK_HZ / 1_000_000);
  localparam int DC_TIMEOUT_US    = 100;
  localparam int DC_TIMEOUT_CYC   = DC_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int ADC_PERIOD_US    = 500;
  localparam int ADC_PERIOD_CYC   = ADC_PERIOD_US * (CLK_HZ / 1_000_000);
endpackage

/* testbench/sfr_core_model.sv */
// core side model: masters the special function register bus, one access at a time
// assumes: the monitor takes writes on the rising edge and answers reads combinationally
`timescale 1ns/1ns
module sfr_core_model (
  // clock
  input  wire logic       clk_sys_in,
  // sfr bus
  output logic      [7:0] sfr_addr_out,
  output logic            sfr_wr_out,
  output logic            sfr_rd_out,
  output logic      [7:0] sfr_wdata_out,
  input  wire logic [7:0] sfr_rdata_in
);
  initial begin
    sfr_addr_out  = 8'h00;
    sfr_wr_out    = 1'b0;
    sfr_rd_out    = 1'b0;
    sfr_wdata_out = 8'h00;
  end
  // released write data is inverted so a stale value is never mistaken for a write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    sfr_addr_out  <= a;
    sfr_wdata_out <= d;
    sfr_wr_out    <= 1'b1;
    @(posedge clk_sys_in);
    sfr_wr_out    <= 1'b0;
    sfr_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    sfr_addr_out <= a;
    sfr_rd_out   <= 1'b1;
    @(negedge clk_sys_in);
    d = sfr_rdata_in;
    @(posedge clk_sys_in);
    sfr_rd_out <= 1'b0;
  endtask
  // key write must be the very next bus write before the protected one
  task automatic keyed_wr(input logic [7:0] d);
    wr(supply_monitor_pkg::ADDR_WRITE_KEY, supply_monitor_pkg::WRITE_KEY_VALUE);
    wr(supply_monitor_pkg::ADDR_POWER_CONTROL, d);
  endtask
endmodule

/* testbench/battery_switchover_monitor_tb_top.sv */
// testbench: sequences of register accesses and supply events with expected values
// assumes: qualification, dc timeout and adc period shortened through parameters
`timescale 1ns/1ns
module battery_switchover_monitor_tb_top;
  localparam int QUAL = 8;
  localparam int DCTO = 4;
  localparam int ADCP = 16;
  logic       clk_sys_in = 1'b0;
  logic       rst_in     = 1'b1;
  logic       dc_low     = 1'b0;
  logic       main_low   = 1'b0;
  logic       pin        = 1'b0;
  logic       dip        = 1'b0;
  logic       rail_done  = 1'b0;
  logic       bat_done   = 1'b0;
  logic [7:0] rail_res   = 8'h00;
  logic [7:0] bat_res    = 8'h00;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;
  logic       adc_start;
  logic       on_bat;
  logic       irq;
  logic [2:0] pctrl;
  int         err_total  = 0;
  int         checks     = 0;
  int         cyc        = 0;
  int         starts     = 0;

  initial forever #25 clk_sys_in = ~clk_sys_in;

  sfr_core_model u_sfr_core_model (.clk_sys_in(clk_sys_in), .sfr_addr_out(addr), .sfr_wr_out(wr),
    .sfr_rd_out(rd), .sfr_wdata_out(wdata), .sfr_rdata_in(rdata));

  battery_switchover_monitor #(.QUALIFY_CYCLES(QUAL), .DC_TIMEOUT_CYC(DCTO), .ADC_PERIOD_CYC(ADCP))
    u_battery_switchover_monitor (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .dc_input_low_in(dc_low), .main_supply_low_in(main_low), .battery_force_pin_in(pin),
    .line_dip_event_in(dip), .rail_adc_done_in(rail_done), .rail_adc_result_in(rail_res),
    .battery_adc_done_in(bat_done), .battery_adc_result_in(bat_res), .rail_adc_start_out(adc_start),
    .rail_on_battery_out(on_bat), .power_irq_out(irq), .power_ctrl_out(pctrl));

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a hang is cut short here rather than by the simulator
  always @(posedge clk_sys_in) begin
    cyc++;
    if (adc_start === 1'b1) starts++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic expect_eq(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic rd_eq(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_sfr_core_model.rd(a, d);
    expect_eq(d, exp);
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_sfr_core_model.wr(a, d);
  endtask
  task automatic out_eq(input logic [7:0] seen_sel, input logic [7:0] exp);
    @(negedge clk_sys_in);
    expect_eq(seen_sel == 8'h00 ? {7'h00, irq} : {5'h00, pctrl}, exp);
  endtask
  // rail must stay put for n cycles, one compare for the whole stretch
  task automatic rail_hold(input int n, input logic v);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge clk_sys_in);
      if (on_bat !== v) ok = 1'b0;
    end
    expect_eq({7'h00, ok}, 8'h01);
  endtask
  task automatic rail_reach(input logic v);
    int n;
    n = 0;
    while (on_bat !== v && n < 40) begin
      @(negedge clk_sys_in);
      n++;
    end
    expect_eq({7'h00, on_bat}, {7'h00, v});
  endtask
  task automatic adc_pulse(input logic bat, input logic [7:0] v);
    @(posedge clk_sys_in);
    if (bat) begin bat_done <= 1'b1; bat_res <= v; end else begin rail_done <= 1'b1; rail_res <= v; end
    @(posedge clk_sys_in);
    bat_done  <= 1'b0;
    rail_done <= 1'b0;
  endtask

  initial begin
    int n0;
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    out_eq(8'h01, 8'h02);
    out_eq(8'h00, 8'h00);
    rd_eq(supply_monitor_pkg::ADDR_SWITCH_CFG, 8'h01);
    rd_eq(supply_monitor_pkg::ADDR_PERIPHERAL_CONFIG_CFG, 8'h40);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    rd_eq(supply_monitor_pkg::ADDR_IRQ_EN_PRIO2, 8'h00);
    rd_eq(8'h00, 8'h00);
    // dc cause is off at reset, but its flag still latches
    @(posedge clk_sys_in) dc_low <= 1'b1;
    rail_hold(30, 1'b0);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h10);
    w(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h10);
    @(posedge clk_sys_in) dc_low <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    w(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    // main supply cause, interrupt masking, flag clearing
    @(posedge clk_sys_in) main_low <= 1'b1;
    rail_reach(1'b1);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h01);
    rd_eq(supply_monitor_pkg::ADDR_PERIPHERAL_CONFIG_CFG, 8'h00);
    w(supply_monitor_pkg::ADDR_POWER_IRQ_EN, 8'h01);
    out_eq(8'h00, 8'h00);
    w(supply_monitor_pkg::ADDR_IRQ_EN_PRIO2, 8'h80);
    out_eq(8'h00, 8'h01);
    w(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'hff);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h01);
    @(posedge clk_sys_in) main_low <= 1'b0;
    rail_hold(QUAL, 1'b1);
    rail_reach(1'b0);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h03);
    rd_eq(supply_monitor_pkg::ADDR_PERIPHERAL_CONFIG_CFG, 8'h40);
    w(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h02);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h02);
    out_eq(8'h00, 8'h00);
    w(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    // global disable keeps the rail on main
    w(supply_monitor_pkg::ADDR_SWITCH_CFG, 8'h02);
    @(posedge clk_sys_in) main_low <= 1'b1;
    rail_hold(30, 1'b0);
    @(posedge clk_sys_in) main_low <= 1'b0;
    // dc cause with two timeout settings; return waits for both supplies
    for (int f = 0; f < 3; f += 2) begin
      w(supply_monitor_pkg::ADDR_SWITCH_CFG, 8'(f << 2));
      @(posedge clk_sys_in) dc_low <= 1'b1;
      rail_hold(DCTO << f, 1'b0);
      rail_reach(1'b1);
      @(posedge clk_sys_in) begin dc_low <= 1'b0; main_low <= 1'b1; end
      rail_hold(3 * QUAL, 1'b1);
      @(posedge clk_sys_in) main_low <= 1'b0;
      rail_reach(1'b0);
    end
    // force pin only counts once enabled as a source
    w(supply_monitor_pkg::ADDR_SWITCH_CFG, 8'h01);
    @(posedge clk_sys_in) pin <= 1'b1;
    rail_hold(20, 1'b0);
    @(posedge clk_sys_in) pin <= 1'b0;
    w(supply_monitor_pkg::ADDR_IRQ_PIN_CFG, 8'h04);
    @(posedge clk_sys_in) pin <= 1'b1;
    rail_reach(1'b1);
    rail_hold(3 * QUAL, 1'b1);
    @(posedge clk_sys_in) pin <= 1'b0;
    rail_reach(1'b0);
    // protected power control write
    w(supply_monitor_pkg::ADDR_POWER_CONTROL, 8'h05);
    out_eq(8'h01, 8'h02);
    w(supply_monitor_pkg::ADDR_WRITE_KEY, supply_monitor_pkg::WRITE_KEY_VALUE);
    w(supply_monitor_pkg::ADDR_DELTA_CFG, 8'h04);
    w(supply_monitor_pkg::ADDR_POWER_CONTROL, 8'h05);
    out_eq(8'h01, 8'h02);
    u_sfr_core_model.keyed_wr(8'h05);
    out_eq(8'h01, 8'h05);
    // conversions: periodic, then one launched by a write just after a periodic one
    n0 = starts;
    repeat (2 * ADCP) @(negedge clk_sys_in);
    expect_eq(8'(starts - n0), 8'h02);
    while (adc_start !== 1'b1) @(negedge clk_sys_in);
    n0 = starts;
    w(supply_monitor_pkg::ADDR_ADC_START, 8'h01);
    repeat (3) @(negedge clk_sys_in);
    // the standing periodic pulse plus the one the write launches
    expect_eq(8'(starts - n0), 8'h02);
    w(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    adc_pulse(1'b0, 8'h10);
    adc_pulse(1'b0, 8'hf0);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h04);
    w(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    adc_pulse(1'b0, 8'hf0);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    // battery flag: new result sets once, a low result keeps setting
    w(supply_monitor_pkg::ADDR_BATTERY_THRESH, 8'h50);
    adc_pulse(1'b1, 8'h60);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h08);
    w(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    w(supply_monitor_pkg::ADDR_BATTERY_RESULT, 8'h11);
    rd_eq(supply_monitor_pkg::ADDR_BATTERY_RESULT, 8'h60);
    adc_pulse(1'b1, 8'h40);
    w(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h00);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h08);
    adc_pulse(1'b1, 8'h60);
    // line dip and the shared interrupt with only the line dip enable set
    @(posedge clk_sys_in) dip <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    dip <= 1'b0;
    w(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h20);
    rd_eq(supply_monitor_pkg::ADDR_POWER_FLAGS, 8'h20);
    w(supply_monitor_pkg::ADDR_POWER_IRQ_EN, 8'h20);
    out_eq(8'h00, 8'h01);
    w(supply_monitor_pkg::ADDR_IRQ_EN_PRIO2, 8'h00);
    out_eq(8'h00, 8'h00);
    tally_and_finish();
  end
endmodule
